// ===== verilog/pec_pkg.sv
// package: register map, field layout, reset values and carrier types of the port error counters
package pec_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // sizes
  localparam int unsigned PEC_PORTS = 4;
  localparam int unsigned PEC_CNT_W = 8;
  localparam int unsigned PEC_PIN_W = 16;
  localparam int unsigned PEC_EVT_W = 12;

  ////////////////////////////////////////////////////////////////////////////////
  // register indices, port 0 in the lowest lane; byte address is four times the index
  localparam logic [3:0][13:0] PEC_IDX_CRC  = {14'h0306, 14'h0304, 14'h0302, 14'h0300};
  localparam logic [3:0][13:0] PEC_IDX_SYM  = {14'h0307, 14'h0305, 14'h0303, 14'h0301};
  localparam logic [3:0][13:0] PEC_IDX_LINK = {14'h0313, 14'h0312, 14'h0311, 14'h0310};
  localparam logic [13:0]      PEC_IDX_STAT = 14'h0320;  // sticky event status, write 1 to clear
  localparam logic [13:0]      PEC_IDX_MASK = 14'h0321;  // interrupt enable, same layout

  ////////////////////////////////////////////////////////////////////////////////
  // field positions in status and mask
  localparam int unsigned PEC_STAT_CRC_LSB  = 0;
  localparam int unsigned PEC_STAT_SYM_LSB  = 4;
  localparam int unsigned PEC_STAT_LINK_LSB = 8;

  // field positions in the filtered pin vector
  localparam int unsigned PEC_PIN_LINK_LSB  = 0;
  localparam int unsigned PEC_PIN_SYM_LSB   = 4;
  localparam int unsigned PEC_PIN_FRM_LSB   = 8;
  localparam int unsigned PEC_PIN_CRC_LSB   = 12;

  ////////////////////////////////////////////////////////////////////////////////
  // values
  localparam logic [7:0] PEC_CNT_MAX = 8'hff;  // counters stop here

  ////////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic [3:0] crc_fail;   // frame check failed, per port
    logic [3:0] rx_frame;   // frame reception in progress, per port
    logic [3:0] sym_err;    // invalid code group seen, per port
    logic [3:0] link_down;  // channel continuity lost, per port
  } pec_phy_ind_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
  } pec_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } pec_apb_rsp_t;

  typedef struct packed {
    logic [PEC_PIN_W-1:0] s1;
    logic [PEC_PIN_W-1:0] s2;
    logic [PEC_PIN_W-1:0] s3;
    logic [PEC_PIN_W-1:0] filt;
    logic [PEC_PIN_W-1:0] rise;
  } pec_filt_st_t;

  typedef struct packed {
    logic [3:0][7:0]       crc_cnt;
    logic [3:0][7:0]       sym_cnt;
    logic [3:0][7:0]       link_cnt;
    logic [PEC_EVT_W-1:0]  stat;
    logic [PEC_EVT_W-1:0]  mask;
    pec_apb_rsp_t          rsp;
    logic                  irq;
  } pec_st_t;

  // reset values: counters, status and mask all clear, bus idle
  localparam pec_filt_st_t PEC_FILT_RST = '0;
  localparam pec_st_t      PEC_ST_RST   = '0;

endpackage

// ===== verilog/pec_pin_filter.sv
// three-stage pin synchroniser with agreement filter and rising-edge pulse
`timescale 1ns/1ps
module pec_pin_filter
  import pec_pkg::*;
(
  // clock and reset
  input  wire logic                 clk_sys_i,
  input  wire logic                 rst_b_i,
  // asynchronous pins
  input  wire logic [PEC_PIN_W-1:0] pin_i,
  // filtered level and one-cycle rise
  output logic      [PEC_PIN_W-1:0] level_o,
  output logic      [PEC_PIN_W-1:0] rise_o
);

  pec_filt_st_t         st_r;
  pec_filt_st_t         st_nxt;
  logic [PEC_PIN_W-1:0] agree;

  // s1 feeds only s2; the filter looks at s2 and s3 alone
  always_comb begin
    st_nxt      = st_r;
    agree       = ~(st_r.s2 ^ st_r.s3);
    st_nxt.s1   = pin_i;
    st_nxt.s2   = st_r.s1;
    st_nxt.s3   = st_r.s2;
    st_nxt.filt = (agree & st_r.s2) | (~agree & st_r.filt);
    st_nxt.rise = agree & st_r.s2 & ~st_r.filt;  // one pulse per accepted rise
  end

  // state register
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_r <= PEC_FILT_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level_o = st_r.filt;
  assign rise_o  = st_r.rise;

endmodule // pec_pin_filter

// ===== verilog/pec_counters.sv
// port error counter bank with APB register access and event interrupt
//
// Overview of operation
// - a loss of channel continuity on a port adds one to that port's link loss counter.
// - the four one-byte link loss counters sit at consecutive indices, port 0 lowest.
// - each symbol error reported by a port's physical layer adds one to its symbol counter.
// - symbol errors count alike inside frames and in the idle time between them.
// - the four symbol error counters sit at odd indices spaced by two from the lowest one.
// - a failed frame check on a port adds one to that port's frame error counter.
// - the frame check result of every received frame is always used, with no way to disable it.
// - frame error counters move only with frame reception, never with idle line activity.
// - the four frame error counters sit at even indices spaced by two, each just below its port's symbol counter.
`timescale 1ns/1ps
module pec_counters
  import pec_pkg::*;
(
  // clock and reset
  input  wire logic          clk_sys_i,
  input  wire logic          rst_b_i,
  // physical layer indications, asynchronous
  input  wire pec_phy_ind_t  phy_ind_i,
  // apb slave
  input  wire pec_apb_req_t  apb_req_i,
  output pec_apb_rsp_t       apb_rsp_o,
  // interrupt
  output logic               irq_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // declarations

  pec_st_t              st_r;
  pec_st_t              st_nxt;
  logic [PEC_PIN_W-1:0] pin_lvl;
  logic [PEC_PIN_W-1:0] pin_rise;
  logic [3:0]           ev_link;
  logic [3:0]           ev_sym;
  logic [3:0]           ev_crc;
  logic [3:0]           frm_lvl;
  logic [PEC_EVT_W-1:0] ev_all;
  logic [PEC_EVT_W-1:0] w1c;
  logic [13:0]          idx;
  logic                 aligned;
  logic                 setup;
  logic                 acc_done;
  logic                 rd_hit;
  logic [31:0]          rd_val;

  ////////////////////////////////////////////////////////////////////////////////
  // pin conditioning

  // all sixteen indications share one filter so their latencies stay equal;
  // that keeps a frame check result aligned with its frame window
  pec_pin_filter u_filter (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .pin_i     (phy_ind_i),
    .level_o   (pin_lvl),
    .rise_o    (pin_rise)
  );

  // per-port events
  assign ev_link = pin_rise[PEC_PIN_LINK_LSB +: 4];
  assign ev_sym  = pin_rise[PEC_PIN_SYM_LSB +: 4];
  assign frm_lvl = pin_lvl[PEC_PIN_FRM_LSB +: 4];
  // a check failure only counts inside a frame; no enable exists
  assign ev_crc  = pin_rise[PEC_PIN_CRC_LSB +: 4] & frm_lvl;

  // event vector in status layout
  assign ev_all  = {ev_link, ev_sym, ev_crc};

  ////////////////////////////////////////////////////////////////////////////////
  // bus decode

  assign idx      = apb_req_i.paddr[15:2];
  assign aligned  = (apb_req_i.paddr[1:0] == 2'h0);
  assign setup    = apb_req_i.psel & ~apb_req_i.penable;
  assign acc_done = apb_req_i.psel & apb_req_i.penable & st_r.rsp.pready;

  // saturating add; a burst must never look like a quiet link
  function automatic logic [7:0] sat_inc(input logic [7:0] v, input logic ev);
    sat_inc = (ev && (v != PEC_CNT_MAX)) ? v + 8'h01 : v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_nxt = st_r;
    rd_hit = 1'b0;
    rd_val = 32'h0000_0000;
    w1c    = '0;

    // read mux over the fixed map
    for (int p = 0; p < PEC_PORTS; p++) begin
      if (idx == PEC_IDX_CRC[p]) begin
        rd_hit = 1'b1;
        rd_val = {24'h00_0000, st_r.crc_cnt[p]};
      end
      if (idx == PEC_IDX_SYM[p]) begin
        rd_hit = 1'b1;
        rd_val = {24'h00_0000, st_r.sym_cnt[p]};
      end
      if (idx == PEC_IDX_LINK[p]) begin
        rd_hit = 1'b1;
        rd_val = {24'h00_0000, st_r.link_cnt[p]};
      end
    end
    if (idx == PEC_IDX_STAT) begin
      rd_hit = 1'b1;
      rd_val = {20'h0_0000, st_r.stat};
    end
    if (idx == PEC_IDX_MASK) begin
      rd_hit = 1'b1;
      rd_val = {20'h0_0000, st_r.mask};
    end
    if (!aligned) begin
      rd_hit = 1'b0;
    end

    // counters, one step per event
    for (int p = 0; p < PEC_PORTS; p++) begin
      st_nxt.link_cnt[p] = sat_inc(st_r.link_cnt[p], ev_link[p]);
      st_nxt.sym_cnt[p]  = sat_inc(st_r.sym_cnt[p], ev_sym[p]);
      st_nxt.crc_cnt[p]  = sat_inc(st_r.crc_cnt[p], ev_crc[p]);
    end

    // bus answer: data is snapshotted in setup, ready in the first access cycle
    st_nxt.rsp.pready = setup;
    if (setup) begin
      st_nxt.rsp.pslverr = ~rd_hit;
      st_nxt.rsp.prdata  = (rd_hit && !apb_req_i.pwrite) ? rd_val : 32'h0000_0000;
    end else if (acc_done) begin
      st_nxt.rsp.pslverr = 1'b0;
      st_nxt.rsp.prdata  = 32'h0000_0000;
    end

    // writes land only at the completing edge; counters ignore writes
    if (acc_done && apb_req_i.pwrite && aligned) begin
      if (idx == PEC_IDX_STAT) begin
        w1c = apb_req_i.pwdata[PEC_EVT_W-1:0];
      end
      if (idx == PEC_IDX_MASK) begin
        st_nxt.mask = apb_req_i.pwdata[PEC_EVT_W-1:0];
      end
    end

    // sticky status: a new event beats a clear in the same cycle
    st_nxt.stat = (st_r.stat & ~w1c) | ev_all;
    st_nxt.irq  = |(st_nxt.stat & st_nxt.mask);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_r <= PEC_ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state flops
  assign apb_rsp_o = st_r.rsp;
  assign irq_o     = st_r.irq;

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb_sys @(posedge clk_sys_i);
  endclocking

  default disable iff (!rst_b_i);

  for (genvar p = 0; p < PEC_PORTS; p++) begin : g_chk

    // a link loss pulse moves its counter by exactly one
    chk_link_incr: assert property (
      ev_link[p] && (st_r.link_cnt[p] != PEC_CNT_MAX)
      |=> st_r.link_cnt[p] == $past(st_r.link_cnt[p]) + 8'h01
    ) else $error("link loss counter did not step by one");

    // the link loss counter is read back at its own index
    chk_link_addr: assert property (
      setup && !apb_req_i.pwrite && aligned && (idx == 14'h0310 + 14'(p))
      |=> st_r.rsp.pready && !st_r.rsp.pslverr
          && (st_r.rsp.prdata == {24'h00_0000, $past(st_r.link_cnt[p])})
    ) else $error("link loss counter read at wrong index or value");

    // a symbol error pulse moves its counter by exactly one
    chk_sym_incr: assert property (
      ev_sym[p] && (st_r.sym_cnt[p] != PEC_CNT_MAX)
      |=> st_r.sym_cnt[p] == $past(st_r.sym_cnt[p]) + 8'h01
    ) else $error("symbol error counter did not step by one");

    // a symbol error between frames still counts and flags
    chk_sym_idle: assert property (
      pin_rise[PEC_PIN_SYM_LSB + p] && !frm_lvl[p] && (st_r.sym_cnt[p] != PEC_CNT_MAX)
      |=> (st_r.sym_cnt[p] != $past(st_r.sym_cnt[p])) && st_r.stat[PEC_STAT_SYM_LSB + p]
    ) else $error("idle symbol error was not counted");

    // symbol counters on odd indices spaced by two
    chk_sym_addr: assert property (
      setup && !apb_req_i.pwrite && aligned && (idx == 14'h0301 + 14'(2 * p))
      |=> st_r.rsp.pready
          && (st_r.rsp.prdata == {24'h00_0000, $past(st_r.sym_cnt[p])})
    ) else $error("symbol error counter read at wrong index or value");

    // a failed check inside a frame moves its counter by exactly one
    chk_crc_incr: assert property (
      ev_crc[p] && (st_r.crc_cnt[p] != PEC_CNT_MAX)
      |=> st_r.crc_cnt[p] == $past(st_r.crc_cnt[p]) + 8'h01
    ) else $error("frame error counter did not step by one");

    // every failed check in a frame is taken, nothing can switch it off
    chk_crc_always: assert property (
      pin_rise[PEC_PIN_CRC_LSB + p] && pin_lvl[PEC_PIN_FRM_LSB + p]
      |=> st_r.stat[PEC_STAT_CRC_LSB + p]
          && (($past(st_r.crc_cnt[p]) == PEC_CNT_MAX)
              || (st_r.crc_cnt[p] != $past(st_r.crc_cnt[p])))
    ) else $error("failed frame check was dropped");

    // outside a frame the frame error counter holds still
    chk_crc_frame: assert property (
      !frm_lvl[p] |=> $stable(st_r.crc_cnt[p])
    ) else $error("frame error counter moved outside a frame");

    // frame counters on even indices, just below their symbol counters
    chk_crc_addr: assert property (
      setup && !apb_req_i.pwrite && aligned && (idx == 14'h0300 + 14'(2 * p))
      |=> st_r.rsp.pready
          && (st_r.rsp.prdata == {24'h00_0000, $past(st_r.crc_cnt[p])})
    ) else $error("frame error counter read at wrong index or value");

    // a full counter stays full whatever arrives; checked every cycle, not only on events
    chk_sat_hold: assert property (
      (($past(st_r.link_cnt[p]) != PEC_CNT_MAX) || (st_r.link_cnt[p] == PEC_CNT_MAX))
      && (($past(st_r.sym_cnt[p]) != PEC_CNT_MAX) || (st_r.sym_cnt[p] == PEC_CNT_MAX))
      && (($past(st_r.crc_cnt[p]) != PEC_CNT_MAX) || (st_r.crc_cnt[p] == PEC_CNT_MAX))
    ) else $error("saturated counter wrapped");

    // without a link loss pulse the counter never moves, bus writes included
    chk_link_hold: assert property (
      !ev_link[p]
      |=> $stable(st_r.link_cnt[p])
    ) else $error("link loss counter moved without an event");

    // without a symbol error pulse the counter never moves
    chk_sym_hold: assert property (
      !ev_sym[p]
      |=> $stable(st_r.sym_cnt[p])
    ) else $error("symbol error counter moved without an event");

    // without an accepted check failure the frame counter never moves
    chk_crc_hold: assert property (
      !ev_crc[p]
      |=> $stable(st_r.crc_cnt[p])
    ) else $error("frame error counter moved without an event");

    // a link loss always leaves its sticky flag behind
    chk_link_stat: assert property (
      ev_link[p]
      |=> st_r.stat[PEC_STAT_LINK_LSB + p]
    ) else $error("link loss did not set its status bit");

    // an accepted check failure always leaves its sticky flag behind
    chk_crc_stat: assert property (
      ev_crc[p]
      |=> st_r.stat[PEC_STAT_CRC_LSB + p]
    ) else $error("frame error did not set its status bit");

    // a symbol error inside a frame counts just like one in idle time
    // so the frame window must never gate the symbol path
    chk_sym_frame: assert property (
      pin_rise[PEC_PIN_SYM_LSB + p] && frm_lvl[p] && (st_r.sym_cnt[p] != PEC_CNT_MAX)
      |=> st_r.sym_cnt[p] == $past(st_r.sym_cnt[p]) + 8'h01
    ) else $error("symbol error inside a frame was not counted");

    // a check failure pulse with no frame open is ignored
    chk_crc_idle: assert property (
      pin_rise[PEC_PIN_CRC_LSB + p] && !frm_lvl[p]
      |=> $stable(st_r.crc_cnt[p])
    ) else $error("frame error counted outside a frame");

  end

  // pready answers one cycle after setup and drops after the access
  chk_bus_ready: assert property (
    setup |=> st_r.rsp.pready ##1 !st_r.rsp.pready || setup
  ) else $error("bus answer timing wrong");

  // unmapped or misaligned address answers with an error
  chk_bus_err: assert property (
    setup && !rd_hit |=> st_r.rsp.pready && st_r.rsp.pslverr
  ) else $error("unmapped access not flagged");

  // an event wins over a clear in the same cycle
  chk_stat_set: assert property (
    (ev_all != 12'h000) |=> ((st_r.stat & $past(ev_all)) == $past(ev_all))
  ) else $error("status event lost against clear");

  // interrupt follows masked status
  chk_irq_level: assert property (
    st_r.irq == |(st_r.stat & st_r.mask)
  ) else $error("interrupt level disagrees with status and mask");

  // a mask write lands whole at the completing edge
  chk_mask_write: assert property (
    acc_done && apb_req_i.pwrite && aligned && (idx == PEC_IDX_MASK)
    |=> st_r.mask == $past(apb_req_i.pwdata[PEC_EVT_W-1:0])
  ) else $error("mask write did not land");

  // writing ones clears status bits unless an event arrives in that cycle
  // software may lose nothing: a racing event keeps its bit
  chk_stat_clear: assert property (
    acc_done && apb_req_i.pwrite && aligned && (idx == PEC_IDX_STAT)
    |=> (st_r.stat & $past(apb_req_i.pwdata[PEC_EVT_W-1:0]) & ~$past(ev_all)) == 12'h000
  ) else $error("status clear by write one failed");

  // outside the access cycle the read bus rests at zero
  chk_bus_idle: assert property (
    !st_r.rsp.pready
    |-> (st_r.rsp.prdata == 32'h0000_0000) && !st_r.rsp.pslverr
  ) else $error("bus answer not idle outside access");

  // a write returns no data, whatever register it hits
  chk_wr_quiet: assert property (
    setup && apb_req_i.pwrite
    |=> st_r.rsp.pready && (st_r.rsp.prdata == 32'h0000_0000)
  ) else $error("write answered with read data");

  // a misaligned word is refused and reads as zero
  chk_bad_align: assert property (
    setup && !aligned
    |=> st_r.rsp.pready && st_r.rsp.pslverr && (st_r.rsp.prdata == 32'h0000_0000)
  ) else $error("misaligned access not refused");

  // unused upper bits of the status word read as zero
  chk_stat_width: assert property (
    setup && !apb_req_i.pwrite && aligned && (idx == PEC_IDX_STAT)
    |=> st_r.rsp.prdata[31:PEC_EVT_W] == 20'h0_0000
  ) else $error("status read carries stray upper bits");

endmodule // pec_counters

// ===== sim/pec_phy_model.sv
// behavioural physical layer transceivers of the four ports
`timescale 1ns/1ps
module pec_phy_model
  import pec_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       rst_b_i,
  // event requests from the bench
  input  wire logic       go_i,
  input  wire logic [1:0] kind_i,
  input  wire logic [3:0] port_i,
  input  wire logic [3:0] frame_i,
  // pins toward the block
  output pec_phy_ind_t    phy_o,
  output logic            busy_o
);
  logic [2:0] cnt_r;
  logic [1:0] kind_r;
  logic [3:0] port_r;
  logic [3:0] hi;

  ////////////////////////////////////////////////////////////////////////////////
  // pin high three cycles then low three, so the filter always sees clean edges
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_r  <= 3'h0;
      kind_r <= 2'h0;
      port_r <= 4'h0;
    end else if (go_i && cnt_r == 3'h0) begin
      cnt_r  <= 3'h6;
      kind_r <= kind_i;
      port_r <= port_i;
    end else if (cnt_r != 3'h0) begin
      cnt_r <= cnt_r - 3'h1;
    end
  end

  // frame level passes straight through; nothing gates the
  always_comb begin
    hi              = (cnt_r > 3'h3) ? port_r : 4'h0;
    phy_o.link_down = (kind_r == 2'h0) ? hi : 4'h0;
    phy_o.sym_err   = (kind_r == 2'h1) ? hi : 4'h0;
    phy_o.crc_fail  = (kind_r == 2'h2) ? hi : 4'h0;
    phy_o.rx_frame  = frame_i;
    busy_o          = (cnt_r != 3'h0);
  end
endmodule // pec_phy_model

// ===== sim/tb_pec_counters.sv
// self-checking bench of the port error counter bank
`timescale 1ns/1ps
module tb_pec_counters
  import pec_pkg::*;
();
  logic         clk_sys_i;
  logic         rst_b_i;
  pec_apb_req_t req;
  pec_apb_rsp_t rsp;
  pec_phy_ind_t phy;
  logic         irq;
  logic         go;
  logic         busy;
  logic [1:0]   kind;
  logic [3:0]   port;
  logic [3:0]   frame;
  logic [7:0]   e_crc [4] = '{4{8'h0}};
  logic [7:0]   e_sym [4] = '{4{8'h0}};
  logic [7:0]   e_link [4] = '{4{8'h0}};
  logic [31:0]  rd;
  logic         er;
  int           err_total;
  int           checks_done;
  int           cyc;

  pec_counters i_pec_counters (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .phy_ind_i(phy),
    .apb_req_i(req), .apb_rsp_o(rsp), .irq_o(irq));
  pec_phy_model i_pec_phy_model (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .go_i(go),
    .kind_i(kind), .port_i(port), .frame_i(frame), .phy_o(phy), .busy_o(busy));

  // 40 MHz clock
  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  // hang guard, far above the few thousand cycles the run needs
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total = err_total + 1;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks=%0d errors=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // one apb transfer; the wait on pready is bounded, never a fixed count
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk_sys_i);
    req.penable <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (rsp.pready !== 1'b1 && n < 50);
    if (n >= 50) err_total++;
    rd = rsp.prdata;
    er = rsp.pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic rdc(input logic [15:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
    chk({31'h0, er}, 32'h0);
  endtask

  function automatic logic [7:0] inc(input logic [7:0] v);
    return (v == 8'hff) ? v : v + 8'h1;
  endfunction

  // one indication through the model, expectations kept alongside
  task automatic ev(input logic [1:0] k, input int p);
    int n;
    @(posedge clk_sys_i);
    go   <= 1'b1;
    kind <= k;
    port <= 4'h1 << p;
    @(posedge clk_sys_i);
    go <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (busy === 1'b1 && n < 20);
    repeat (2) @(posedge clk_sys_i);
    if (k == 2'h0) e_link[p] = inc(e_link[p]);
    if (k == 2'h1) e_sym[p] = inc(e_sym[p]);
    if (k == 2'h2 && frame[p]) e_crc[p] = inc(e_crc[p]);
  endtask

  task automatic check_all();
    for (int p = 0; p < 4; p++) begin
      rdc(16'h0c00 + 16'(8 * p), {24'h0, e_crc[p]});
      rdc(16'h0c04 + 16'(8 * p), {24'h0, e_sym[p]});
      rdc(16'h0c40 + 16'(4 * p), {24'h0, e_link[p]});
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // scenarios; port p gets p+1 events to expose swapped addresses, except that t_sym's extra port 1 event gives ports 1 and 2 equal symbol counts
  task automatic t_link();
    for (int p = 0; p < 4; p++) for (int i = 0; i <= p; i++) ev(2'h0, p);
    check_all();
  endtask

  task automatic t_sym();
    for (int p = 0; p < 4; p++) for (int i = 0; i <= p; i++) ev(2'h1, p);
    @(posedge clk_sys_i);
    frame <= 4'h2;
    ev(2'h1, 1);
    @(posedge clk_sys_i);
    frame <= 4'h0;
    check_all();
  endtask

  task automatic t_crc();
    @(posedge clk_sys_i);
    frame <= 4'hf;
    for (int p = 0; p < 4; p++) for (int i = 0; i <= p; i++) ev(2'h2, p);
    @(posedge clk_sys_i);
    frame <= 4'h0;
    repeat (4) @(posedge clk_sys_i);
    ev(2'h2, 0);
    check_all();
  endtask

  task automatic t_irq();
    rdc(16'h0c80, 32'hfff);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, 16'h0c84, 32'h010);
    repeat (3) @(posedge clk_sys_i);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, 16'h0c80, 32'h010);
    repeat (3) @(posedge clk_sys_i);
    chk({31'h0, irq}, 32'h0);
    rdc(16'h0c80, 32'hfef);
    apb(1'b1, 16'h0c80, 32'hfff);
    rdc(16'h0c80, 32'h0);
    ev(2'h1, 0);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, 16'h0c04, 32'h55);
    chk({31'h0, er}, 32'h0);
    rdc(16'h0c04, {24'h0, e_sym[0]});
  endtask

  task automatic t_rst();
    check_all();
    rdc(16'h0c84, 32'h0);
  endtask

  task automatic t_sat();
    repeat (256) ev(2'h1, 3);
    check_all();
  endtask

  task automatic t_bad();
    apb(1'b0, 16'h0c20, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, er}, 32'h1);
    apb(1'b0, 16'h0c01, 32'h0);
    chk({31'h0, er}, 32'h1);
  endtask

  initial begin
    rst_b_i = 1'b0;
    req     = '0;
    go      = 1'b0;
    kind    = 2'h0;
    port    = 4'h0;
    frame   = 4'h0;
    repeat (2) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    t_rst();
    t_link();
    t_sym();
    t_crc();
    t_irq();
    t_bad();
    t_sat();
    results();
  end
endmodule // tb_pec_counters
